/* File: rtl/csm_bus_if.sv */
// CAN bus wire shared by the controller and a far node
`timescale 1ns/1ps
interface csm_bus_if;
  logic dev_tx;
  logic node_o;
  logic node_oe;
  logic rx_level;
  // Wired-AND: dominant (0) from either party wins
  assign rx_level = dev_tx & ~(node_oe & ~node_o);
  modport dev (output dev_tx, input rx_level);
  modport node (output node_o, output node_oe, input rx_level);
endinterface : csm_bus_if

/* File: rtl/csm_ctrl.sv */
// CAN controller end: power-save modes, interrupt sources and receive-only gating
// Behaviour
// RULE1: stop request 11B accepted only from sleep
// RULE2: only 01B write leaves stop, into sleep
// RULE3: no transmission while in stop mode
// RULE4: operating clock stopped on entering stop
// RULE5: stop mode accepts only power-save field writes
// RULE6: pointer registers unreadable in stop mode
// RULE7: message buffers blocked in stop mode
// RULE8: entering stop clears buffer access flag
// RULE9: mode requests ignored while in stop
// RULE10: bus edge in sleep beats stop request
// RULE11: sleep bus edge sets wakeup, resumes mode
// RULE12: wakeup detection works with core clock stopped
// RULE13: six latched sources feed four outputs
// RULE14: status bits stick until software clears
// RULE15: sources map to tx, rx, err, wake
// RULE16: per-buffer enable gates tx/rx sources
// RULE17: error counter warning, passive, bus-off raise error; code raises it only on the rise to warning level (TEC_WARN or rx_err_warn)
// RULE18: any protocol error raises protocol source
// RULE19: receive-only transmits nothing, requests stay pending
// RULE20: receive-only holds transmit pin recessive
// RULE21: receive-only never updates transmit error counter
// RULE22: valid reception sets valid flag always; code sets it only outside OPM_INIT
// RULE23: writing 00B releases sleep to old mode
// RULE24: output high when status and enable set
`timescale 1ns/1ps
module csm_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protocol core events (one-cycle pulses)
  input wire logic ev_tx_ok,
  input wire logic [3:0] ev_tx_buf,
  input wire logic ev_rx_ok,
  input wire logic ev_rx_stored,
  input wire logic [3:0] ev_rx_buf,
  input wire logic ev_proto_err,
  input wire logic ev_arb_lost,
  input wire logic ev_tx_err,
  // Protocol core levels
  input wire logic rx_err_warn,
  input wire logic bus_idle,
  input wire logic tx_pending,
  input wire logic core_tx_bit,
  // Core control
  output logic tx_allowed,
  output logic core_clk_en,
  // Interrupt requests
  output logic tx_irq_out,
  output logic rx_irq_out,
  output logic err_irq_out,
  output logic wake_irq_out,
  // CAN bus
  csm_bus_if.dev bus
);
  typedef struct packed {
    csm_pkg::csm_ps_type ps;
    csm_pkg::csm_opm_type opm;
    logic valid;
    logic [5:0] ints, ie;
    logic [15:0] buf_ie;
    logic [8:0] transmit_error_counter;
    logic [3:0] lipt, rgpt, lopt, tgpt;
    logic [15:0][31:0] mb;
    logic rx_prev, err_prev;
    logic pready, pslverr;
    logic [31:0] prdata;
    logic tx_pin, tx_ok_out, clk_en;
    logic [3:0] irq;
  } csm_st_type;
  csm_st_type st_q;
  csm_st_type st_d;
  // Address match, used for reads and writes alike
  function automatic logic csm_hit(input logic [11:0] a, input logic [11:0] off);
    csm_hit = (a == off);
  endfunction : csm_hit
  ////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic wr, rd, awake, fall, err_lvl, mb_hit;
    logic [5:0] set;
    logic [1:0] wps;
    logic [3:0] mbi;
    wr = 1'b0;
    rd = 1'b0;
    awake = 1'b0;
    fall = 1'b0;
    err_lvl = 1'b0;
    set = 6'h00;
    wps = 2'b00;
    mbi = 4'h0;
    mb_hit = 1'b0;
    st_d = st_q;
    // APB: answer one cycle into the access phase; error flag stands only with it
    st_d.pslverr = 1'b0;
    st_d.pready = psel & penable & ~st_q.pready;
    wr = psel & penable & st_q.pready & pwrite;
    rd = psel & penable & ~st_q.pready & ~pwrite;
    awake = (st_q.ps == csm_pkg::PS_OP);
    wps = pwdata[csm_pkg::PS_LSB +: 2];
    mb_hit = (paddr >= csm_pkg::MB_OFF) && (paddr <= csm_pkg::MB_END) && (paddr[1:0] == 2'b00);
    mbi = paddr[5:2];
    // Bus edge sampled on the always-on clock, not the core clock
    st_d.rx_prev = bus.rx_level;
    fall = st_q.rx_prev & ~bus.rx_level;
    // Core events only count while the core clock runs
    if (awake) begin
      // RULE16 per-buffer gating
      set[csm_pkg::SRC_TX] = ev_tx_ok & st_q.buf_ie[ev_tx_buf];
      set[csm_pkg::SRC_RX] = ev_rx_ok & ev_rx_stored & st_q.buf_ie[ev_rx_buf];
      // RULE18 protocol error source
      set[csm_pkg::SRC_PROTO] = ev_proto_err;
      set[csm_pkg::SRC_ARB] = ev_arb_lost;
      // RULE21 counter frozen in receive-only
      if (ev_tx_err && st_q.opm != csm_pkg::OPM_RXONLY && st_q.transmit_error_counter < csm_pkg::TEC_BUSOFF) begin
        st_d.transmit_error_counter = st_q.transmit_error_counter + csm_pkg::TEC_STEP;
      end
      // RULE17 error-state rise
      err_lvl = (st_q.transmit_error_counter >= csm_pkg::TEC_WARN) | rx_err_warn;
      st_d.err_prev = err_lvl;
      set[csm_pkg::SRC_ERR] = err_lvl & ~st_q.err_prev;
      // RULE22 valid reception, stored or not
      if (ev_rx_ok && st_q.opm != csm_pkg::OPM_INIT) begin
        st_d.valid = 1'b1;
      end
      if (ev_rx_ok && ev_rx_stored) begin
        st_d.lipt = ev_rx_buf;
        st_d.rgpt = st_q.rgpt + 4'h1;
      end
      if (ev_tx_ok) begin
        st_d.lopt = ev_tx_buf;
        st_d.tgpt = st_q.tgpt + 4'h1;
      end
    end
    // Register writes
    if (wr) begin
      if (csm_hit(paddr, csm_pkg::CTRL_OFF)) begin
        case (st_q.ps)
          csm_pkg::PS_OP: begin
            // RULE9 mode change only when fully awake
            st_d.opm = csm_pkg::csm_opm_type'(pwdata[csm_pkg::OPM_LSB +: 2]);
            st_d.valid = (st_q.valid & pwdata[csm_pkg::VALID_BIT]) | (st_d.valid & ~st_q.valid); // Reception sets a clear flag; once the flag is set, the written bit decides
            // Sleep only from an operating mode on an idle bus
            if (wps == 2'b01 && st_q.opm != csm_pkg::OPM_INIT && bus_idle && !tx_pending
                && pwdata[csm_pkg::OPM_LSB +: 2] != 2'b00) begin
              st_d.ps = csm_pkg::PS_SLEEP;
            end
          end
          csm_pkg::PS_SLEEP: begin
            // RULE23 release to the remembered mode
            if (wps == 2'b00) begin
              st_d.ps = csm_pkg::PS_OP;
            end else if (wps == 2'b11) begin
              // RULE1 stop only from sleep
              st_d.ps = csm_pkg::PS_STOP;
            end
          end
          csm_pkg::PS_STOP: begin
            // RULE2 only 01B leaves stop
            if (wps == 2'b01) begin
              st_d.ps = csm_pkg::PS_SLEEP;
            end
          end
          default: begin
            st_d.ps = csm_pkg::PS_OP;
          end
        endcase
      end else if (!awake) begin
        // RULE5 all other writes dropped while asleep or stopped
        st_d.ps = st_q.ps;
      end else if (csm_hit(paddr, csm_pkg::INTS_OFF)) begin
        // RULE14 software clears by writing 0
        st_d.ints = st_q.ints & pwdata[5:0];
      end else if (csm_hit(paddr, csm_pkg::IE_OFF)) begin
        st_d.ie = pwdata[5:0];
      end else if (csm_hit(paddr, csm_pkg::BUFIE_OFF)) begin
        st_d.buf_ie = pwdata[15:0];
      end else if (mb_hit) begin
        st_d.mb[mbi] = pwdata;
      end
    end
    // RULE11 bus edge wakes sleep, beats a stop write
    // RULE10 stop request lost to the edge
    // RULE2 stop ignores the bus
    if (fall && st_q.ps == csm_pkg::PS_SLEEP) begin
      st_d.ps = csm_pkg::PS_OP;
      set[csm_pkg::SRC_WAKE] = 1'b1;
    end
    // RULE14 set wins over clear
    st_d.ints = st_d.ints | set;
    // Register reads: unmapped address reports an error
    if (rd) begin
      st_d.prdata = csm_pkg::WORD_ZERO;
      st_d.pslverr = 1'b0;
      if (csm_hit(paddr, csm_pkg::CTRL_OFF)) begin
        st_d.prdata[3:0] = {st_q.opm, st_q.ps};
        st_d.prdata[csm_pkg::VALID_BIT] = st_q.valid;
      end else if (csm_hit(paddr, csm_pkg::INTS_OFF)) begin
        st_d.prdata[5:0] = st_q.ints;
      end else if (csm_hit(paddr, csm_pkg::IE_OFF)) begin
        st_d.prdata[5:0] = st_q.ie;
      end else if (csm_hit(paddr, csm_pkg::GCTRL_OFF)) begin
        // RULE8 access flag low whenever not awake
        st_d.prdata[0] = awake & (st_q.opm != csm_pkg::OPM_INIT);
      end else if (csm_hit(paddr, csm_pkg::LIPT_OFF)) begin
        // RULE6 pointers read zero unless awake
        st_d.prdata[3:0] = awake ? st_q.lipt : 4'h0;
      end else if (csm_hit(paddr, csm_pkg::RGPT_OFF)) begin
        st_d.prdata[3:0] = awake ? st_q.rgpt : 4'h0;
      end else if (csm_hit(paddr, csm_pkg::LOPT_OFF)) begin
        st_d.prdata[3:0] = awake ? st_q.lopt : 4'h0;
      end else if (csm_hit(paddr, csm_pkg::TGPT_OFF)) begin
        st_d.prdata[3:0] = awake ? st_q.tgpt : 4'h0;
      end else if (csm_hit(paddr, csm_pkg::BUFIE_OFF)) begin
        st_d.prdata[15:0] = st_q.buf_ie;
      end else if (csm_hit(paddr, csm_pkg::TEC_OFF)) begin
        st_d.prdata[8:0] = st_q.transmit_error_counter;
      end else if (mb_hit) begin
        // RULE7 buffers blocked while asleep or stopped
        st_d.prdata = awake ? st_q.mb[mbi] : csm_pkg::WORD_ZERO;
      end else begin
        st_d.pslverr = 1'b1;
      end
    end else if (psel & penable & ~st_q.pready) begin
      st_d.pslverr = ~(mb_hit | (paddr <= csm_pkg::TEC_OFF && paddr[1:0] == 2'b00));
    end
    // RULE4 core clock runs only when awake
    // RULE12 wakeup path above needs no core clock
    st_d.clk_en = (st_d.ps == csm_pkg::PS_OP);
    // RULE3 no frames in sleep or stop
    // RULE19 no frames in receive-only, requests stay pending
    st_d.tx_ok_out = st_d.clk_en & (st_d.opm == csm_pkg::OPM_NORMAL);
    // RULE20 pin recessive unless allowed to send
    st_d.tx_pin = st_d.tx_ok_out ? core_tx_bit : 1'b1;
    // RULE13 six sources, four requests
    // RULE15 source to output mapping
    // RULE24 status and enable both set
    st_d.irq[0] = st_d.ints[csm_pkg::SRC_TX] & st_d.ie[csm_pkg::SRC_TX];
    st_d.irq[1] = st_d.ints[csm_pkg::SRC_RX] & st_d.ie[csm_pkg::SRC_RX];
    st_d.irq[2] = |(st_d.ints[4:2] & st_d.ie[4:2]);
    st_d.irq[3] = st_d.ints[csm_pkg::SRC_WAKE] & st_d.ie[csm_pkg::SRC_WAKE];
  end
  ////////////////////////////////////////////////////////////////
  // State register; buffers cleared too so no state is undefined
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{ps: csm_pkg::PS_OP, opm: csm_pkg::OPM_INIT, ints: csm_pkg::INTS_RST, ie: csm_pkg::IE_RST,
        buf_ie: csm_pkg::BUFIE_RST, rx_prev: 1'b1, tx_pin: 1'b1, clk_en: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign tx_allowed = st_q.tx_ok_out;
  assign core_clk_en = st_q.clk_en;
  assign tx_irq_out = st_q.irq[0];
  assign rx_irq_out = st_q.irq[1];
  assign err_irq_out = st_q.irq[2];
  assign wake_irq_out = st_q.irq[3];
  assign bus.dev_tx = st_q.tx_pin;
endmodule : csm_ctrl

/* File: rtl/csm_node.sv */
// Far CAN node: drives dominant bits on request and watches the bus
`timescale 1ns/1ps
module csm_node (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bus side
  csm_bus_if.node bus,
  // User side
  input wire logic drive_dominant,
  output logic bus_level,
  output logic bus_fall
);
  typedef struct packed {
    logic drive;
    logic lvl;
    logic fall;
  } csm_node_st_type;

  csm_node_st_type st_q;
  csm_node_st_type st_d;

  ////////////////////////////////////////////////////////////////
  // Next state: edge seen against the last sampled level
  always_comb begin
    st_d = st_q;
    st_d.drive = drive_dominant;
    st_d.lvl = bus.rx_level;
    st_d.fall = st_q.lvl & ~bus.rx_level;
  end

  // State register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{drive: 1'b0, lvl: 1'b1, fall: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Open-drain: only ever pulls low
  assign bus.node_o = 1'b0;
  assign bus.node_oe = st_q.drive;
  assign bus_level = st_q.lvl;
  assign bus_fall = st_q.fall;
endmodule : csm_node

/* File: rtl/csm_pkg.sv */
// Shared constants and types for the CAN power-save and interrupt controller
package csm_pkg;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] INTS_OFF = 12'h004;
  localparam logic [11:0] IE_OFF = 12'h008;
  localparam logic [11:0] GCTRL_OFF = 12'h00C;
  localparam logic [11:0] LIPT_OFF = 12'h010;
  localparam logic [11:0] RGPT_OFF = 12'h014;
  localparam logic [11:0] LOPT_OFF = 12'h018;
  localparam logic [11:0] TGPT_OFF = 12'h01C;
  localparam logic [11:0] BUFIE_OFF = 12'h020;
  localparam logic [11:0] TEC_OFF = 12'h024;
  localparam logic [11:0] MB_OFF = 12'h040;
  localparam logic [11:0] MB_END = 12'h07C;
  // Field positions in the module control register
  localparam int PS_LSB = 0;
  localparam int OPM_LSB = 2;
  localparam int VALID_BIT = 8;
  // Interrupt source indices
  localparam int SRC_TX = 0;
  localparam int SRC_RX = 1;
  localparam int SRC_ERR = 2;
  localparam int SRC_PROTO = 3;
  localparam int SRC_ARB = 4;
  localparam int SRC_WAKE = 5;
  localparam int NUM_SRC = 6;
  localparam int NUM_MB = 16;
  // Error counter levels and step
  localparam logic [8:0] TEC_WARN = 9'h060;
  localparam logic [8:0] TEC_PASSIVE = 9'h080;
  localparam logic [8:0] TEC_BUSOFF = 9'h100;
  localparam logic [8:0] TEC_STEP = 9'h008;
  // Reset values
  localparam logic [5:0] INTS_RST = 6'h00;
  localparam logic [5:0] IE_RST = 6'h00;
  localparam logic [15:0] BUFIE_RST = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Power-save field values
  typedef enum logic [1:0] {
    PS_OP = 2'b00,
    PS_SLEEP = 2'b01,
    PS_RSVD = 2'b10,
    PS_STOP = 2'b11
  } csm_ps_type;
  // Operating modes
  typedef enum logic [1:0] {
    OPM_INIT = 2'b00,
    OPM_NORMAL = 2'b01,
    OPM_RXONLY = 2'b10,
    OPM_RSVD = 2'b11
  } csm_opm_type;
endpackage : csm_pkg

/* File: tb/can_stop_mode_irq_rxonly_tb.sv */
// Self-checking bench joining the controller and a far node
`timescale 1ns/1ps
module can_stop_mode_irq_rxonly_tb;
  logic clk_sys = 1'b0;
  logic reset_n, psel, penable, pwrite, pready, pslverr, stored, drive_dom, core_tx_bit;
  logic tx_allowed, core_clk_en, bus_level, bus_fall, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, mbv;
  logic [31:0] seed2 = 32'h0000_005D;
  logic [15:0] bufie;
  logic [4:0] evv;
  logic [3:0] ev_buf, irqv, b;
  int miscompares, check_count, src;
  csm_bus_if bus_if_inst ();
  csm_ctrl csm_ctrl_inst (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev_tx_ok(evv[0]),
    .ev_tx_buf(ev_buf), .ev_rx_ok(evv[1]), .ev_rx_stored(stored), .ev_rx_buf(ev_buf), .ev_proto_err(evv[2]),
    .ev_arb_lost(evv[3]), .ev_tx_err(evv[4]), .rx_err_warn(1'b0), .bus_idle(1'b1), .tx_pending(1'b0),
    .core_tx_bit(core_tx_bit), .tx_allowed(tx_allowed), .core_clk_en(core_clk_en), .tx_irq_out(irqv[0]),
    .rx_irq_out(irqv[1]), .err_irq_out(irqv[2]), .wake_irq_out(irqv[3]), .bus(bus_if_inst.dev));
  csm_node csm_node_inst (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus_if_inst.node), .drive_dominant(drive_dom),
    .bus_level(bus_level), .bus_fall(bus_fall));
  csm_properties csm_properties_inst (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .tx_allowed(tx_allowed), .core_clk_en(core_clk_en),
    .core_tx_bit(core_tx_bit), .tx_irq_out(irqv[0]), .rx_irq_out(irqv[1]), .err_irq_out(irqv[2]),
    .wake_irq_out(irqv[3]), .dev_tx(bus_if_inst.dev_tx), .node_o(bus_if_inst.node_o),
    .node_oe(bus_if_inst.node_oe), .rx_level(bus_if_inst.rx_level), .bus_fall(bus_fall));
  ////////////////////////////////////////////////////////////
  // Clock and a random core bit stream
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    seed2 <= xs(seed2);
    core_tx_bit <= seed2[0];
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Which request output a source lands on
  function automatic logic [3:0] out_of(input int s);
    return (s == 0) ? 4'h1 : (s == 1) ? 4'h2 : (s == 5) ? 4'h8 : 4'h4;
  endfunction : out_of
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////
  // APB master: hold the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask : rdc
  // One-cycle core event, then let the status settle
  task automatic ev(input int k, input logic [3:0] bf);
    @(posedge clk_sys);
    evv[k] <= 1'b1;
    ev_buf <= bf;
    @(posedge clk_sys);
    evv <= 5'h0;
    repeat (3) @(posedge clk_sys);
  endtask : ev
  task automatic finish_test;
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  initial begin
    {reset_n, psel, penable, pwrite, stored, drive_dom} = 6'h00;
    {paddr, pwdata, evv, ev_buf, miscompares, check_count} = '0;
    seed = 32'h0000_005D;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc(csm_pkg::CTRL_OFF, 32'h0000_0000, "ctrl reset");
    rdc(csm_pkg::INTS_OFF, 32'h0000_0000, "status reset");
    rdc(csm_pkg::IE_OFF, 32'h0000_0000, "enable reset");
    rdc(csm_pkg::BUFIE_OFF, 32'h0000_0000, "buffer enable reset");
    rdc(12'h030, 32'h0000_0000, "unmapped data");
    chk("unmapped error", 32'h0000_0001, {31'h0, e});
    apb(1'b1, csm_pkg::CTRL_OFF, 32'h0000_0003);
    rdc(csm_pkg::CTRL_OFF, 32'h0000_0000, "stop from operating");
    apb(1'b1, csm_pkg::CTRL_OFF, 32'h0000_0004);
    apb(1'b1, csm_pkg::IE_OFF, 32'h0000_003F);
    seed = xs(seed);
    b = seed[3:0];
    bufie = (seed[31:16] | (16'h0001 << b)) & ~(16'h0001 << (b ^ 4'h1));
    apb(1'b1, csm_pkg::BUFIE_OFF, {16'h0000, bufie});
    rdc(csm_pkg::BUFIE_OFF, {16'h0000, bufie}, "buffer enable");
    mbv = xs(seed);
    apb(1'b1, csm_pkg::MB_OFF, mbv);
    ev(0, b ^ 4'h1);
    rdc(csm_pkg::INTS_OFF, 32'h0000_0000, "disabled buffer");
    ev(1, b);
    rdc(csm_pkg::CTRL_OFF, 32'h0000_0104, "valid unstored");
    rdc(csm_pkg::INTS_OFF, 32'h0000_0000, "unstored frame");
    stored <= 1'b1;
    // Tx, rx, protocol and arbitration sources in turn, latched then cleared
    for (int i = 0; i < 4; i++) begin
      src = (i < 2) ? i : i + 1;
      ev(i, b);
      chk("request outputs", {28'h0, out_of(src)}, {28'h0, irqv});
      rdc(csm_pkg::INTS_OFF, 32'h0000_0001 << src, "latched source");
      apb(1'b1, csm_pkg::INTS_OFF, 32'h0000_0000);
      @(posedge clk_sys);
      chk("cleared outputs", 32'h0000_0000, {28'h0, irqv});
    end
    repeat (12) ev(4, b);
    rdc(csm_pkg::TEC_OFF, 32'(csm_pkg::TEC_STEP) * 12, "error count");
    rdc(csm_pkg::INTS_OFF, 32'h0000_0004, "warning level");
    apb(1'b1, csm_pkg::INTS_OFF, 32'h0000_0000);
    apb(1'b1, csm_pkg::CTRL_OFF, 32'h0000_0008);
    ev(4, b);
    rdc(csm_pkg::TEC_OFF, 32'(csm_pkg::TEC_STEP) * 12, "count frozen");
    chk("receive-only blocked", 32'h0000_0000, {31'h0, tx_allowed});
    chk("pin recessive", 32'h0000_0001, {31'h0, bus_if_inst.dev_tx});
    // Sleep, stop, and the ways out of them
    apb(1'b1, csm_pkg::CTRL_OFF, 32'h0000_0009);
    @(posedge clk_sys);
    chk("clock stopped", 32'h0000_0000, {31'h0, core_clk_en});
    apb(1'b1, csm_pkg::CTRL_OFF, 32'h0000_0003);
    rdc(csm_pkg::CTRL_OFF, 32'h0000_000B, "stop entered");
    rdc(csm_pkg::GCTRL_OFF, 32'h0000_0000, "buffer access flag");
    apb(1'b1, csm_pkg::IE_OFF, 32'h0000_0000);
    rdc(csm_pkg::IE_OFF, 32'h0000_003F, "write in stop");
    rdc(csm_pkg::RGPT_OFF, 32'h0000_0000, "pointer in stop");
    rdc(csm_pkg::MB_OFF, 32'h0000_0000, "buffer in stop");
    apb(1'b1, csm_pkg::CTRL_OFF, 32'h0000_0000);
    rdc(csm_pkg::CTRL_OFF, 32'h0000_000B, "mode request in stop");
    drive_dom <= 1'b1;
    repeat (4) @(posedge clk_sys);
    drive_dom <= 1'b0;
    rdc(csm_pkg::CTRL_OFF, 32'h0000_000B, "bus edge in stop");
    apb(1'b1, csm_pkg::CTRL_OFF, 32'h0000_0001);
    rdc(csm_pkg::CTRL_OFF, 32'h0000_0009, "stop released");
    drive_dom <= 1'b1;
    repeat (4) @(posedge clk_sys);
    drive_dom <= 1'b0;
    rdc(csm_pkg::CTRL_OFF, 32'h0000_0008, "woken mode");
    chk("wake output", 32'h0000_0008, {28'h0, irqv});
    rdc(csm_pkg::INTS_OFF, 32'h0000_0020, "wake status");
    rdc(csm_pkg::MB_OFF, mbv, "buffer kept");
    apb(1'b1, csm_pkg::CTRL_OFF, 32'h0000_0009);
    apb(1'b1, csm_pkg::CTRL_OFF, 32'h0000_0000);
    rdc(csm_pkg::CTRL_OFF, 32'h0000_0008, "software release");
    finish_test();
  end
endmodule : can_stop_mode_irq_rxonly_tb

/* File: tb/csm_properties.sv */
// Concurrent checks on the controller ports and the shared bus wire
`timescale 1ns/1ps
module csm_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Controller levels
  input wire logic tx_allowed,
  input wire logic core_clk_en,
  input wire logic core_tx_bit,
  input wire logic tx_irq_out,
  input wire logic rx_irq_out,
  input wire logic err_irq_out,
  input wire logic wake_irq_out,
  // Bus wire and far node
  input wire logic dev_tx,
  input wire logic node_o,
  input wire logic node_oe,
  input wire logic rx_level,
  input wire logic bus_fall
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // One wait state, then an answer that stands one cycle
  sequence s_answer;
    !pready ##1 pready ##1 !pready;
  endsequence
  a_apb_one_wait: assert property ($rose(penable) && psel |-> s_answer) else $error("APB answer timing wrong");
  a_slverr_with_ready: assert property (pslverr |-> pready) else $error("Error flag without ready");
  ////////////////////////////////////////////////////////////
  // Transmit gating: a blocked node may only show recessive
  a_blocked_recessive: assert property (!tx_allowed |-> dev_tx) else $error("Dominant while blocked");
  a_clock_off_quiet: assert property (!core_clk_en |-> !tx_allowed) else $error("Transmit with clock off");
  a_tx_follows_core: assert property (tx_allowed && $past(tx_allowed) |-> dev_tx == $past(core_tx_bit))
    else $error("Transmit pin lost core bit");
  // Status only drops through a software write
  a_irq_fall_write: assert property ($fell(tx_irq_out) || $fell(rx_irq_out) || $fell(err_irq_out)
    || $fell(wake_irq_out) |-> $past(pready && pwrite)) else $error("Interrupt dropped alone");
  a_wake_clock_on: assert property ($rose(wake_irq_out) |-> core_clk_en) else $error("Wake left clock off");
  ////////////////////////////////////////////////////////////
  // Wire level and the node's edge detector
  a_wired_and: assert property (rx_level == (dev_tx & ~(node_oe & ~node_o))) else $error("Bus level wrong");
  a_fall_pulse: assert property ($fell(rx_level) |=> bus_fall) else $error("Bus fall not flagged");
  a_fall_exact: assert property (bus_fall |-> !$past(rx_level) && $past(rx_level, 2))
    else $error("Bus fall without edge");
endmodule : csm_properties
